// >>> hw/ivp_top.sv
// Behaviour
// - Keypad flag with its enable requests vector 15 at DFE0/DFE1.
// - Periodic tick flag with enable requests vector 12.
// - Low-frequency wake-id flag with enable requests vector 11 in data mode.
// - Carrier flag with enable requests vector 11 in carrier mode.
// - Decode-error flag with enable requests vector 11 in Manchester mode.
// - Byte-received flag with enable requests vector 11 in Manchester mode.
// - Radio buffer-sent flag, gated by radio enable, requests vector 9.
// - Radio error flag shares vector 9 and the same radio enable.
// - Timer overflow flag with enable requests vector 7.
// - Timer channel 1 requests vector 6, channel 0 vector 5.
// - Wakeup interval flag requests vector 4 when interval field nonzero.
// - Low-supply flag with irq enable and reset enable clear requests vector 3.
// - Software trap opcode always takes vector 1 at DFFC/DFFD.
// - Power-on and periodic reset fetch vector 0 at DFFE/DFFF.
// - Watchdog timeout when enabled, or low supply with reset enable, resets.
// - Temperature back in range with restart enable resets to vector 0.
// - Illegal opcode or illegal address forces reset through vector 0.
// - Lowest pending vector number is served first.
// - Vector is two bytes, high byte at the lower location.
// - Flags other than the wakeup interval flag request only with local enable; CPU applies its own mask.
// - Any vector request wakes the processor from stop.
`timescale 1ns/10ps
`default_nettype none

module ivp_top
  import ivp_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        KEYPAD_WAKE_FLAG_IN,
  input  wire logic        KEYPAD_WAKE_IRQ_EN_IN,
  input  wire logic        PERIODIC_TICK_FLAG_IN,
  input  wire logic        PERIODIC_TICK_IRQ_EN_IN,
  input  wire logic [1:0]  LOWFREQ_MODE_IN,
  input  wire logic        LOWFREQ_WAKE_ID_FLAG_IN,
  input  wire logic        LOWFREQ_WAKE_ID_IRQ_EN_IN,
  input  wire logic        LOWFREQ_CARRIER_FLAG_IN,
  input  wire logic        LOWFREQ_CARRIER_IRQ_EN_IN,
  input  wire logic        LOWFREQ_DECODE_ERR_FLAG_IN,
  input  wire logic        LOWFREQ_DECODE_ERR_IRQ_EN_IN,
  input  wire logic        LOWFREQ_BYTE_RX_FLAG_IN,
  input  wire logic        LOWFREQ_BYTE_RX_IRQ_EN_IN,
  input  wire logic        RADIO_BUFFER_SENT_FLAG_IN,
  input  wire logic        RADIO_TX_ERROR_FLAG_IN,
  input  wire logic        RADIO_IRQ_EN_IN,
  input  wire logic        TIMER_OVERFLOW_FLAG_IN,
  input  wire logic        TIMER_OVERFLOW_IRQ_EN_IN,
  input  wire logic        TIMER_CHAN1_FLAG_IN,
  input  wire logic        TIMER_CHAN1_IRQ_EN_IN,
  input  wire logic        TIMER_CHAN0_FLAG_IN,
  input  wire logic        TIMER_CHAN0_IRQ_EN_IN,
  input  wire logic        WAKEUP_INTERVAL_FLAG_IN,
  input  wire logic [5:0]  WAKEUP_INTERVAL_FIELD_IN,
  input  wire logic        LOW_SUPPLY_FLAG_IN,
  input  wire logic        LOW_SUPPLY_IRQ_EN_IN,
  input  wire logic        LOW_SUPPLY_RESET_EN_IN,
  input  wire logic        POWER_ON_RESET_IN,
  input  wire logic        PERIODIC_RESET_FLAG_IN,
  input  wire logic [5:0]  PERIODIC_RESET_INTERVAL_IN,
  input  wire logic        WATCHDOG_TIMEOUT_IN,
  input  wire logic        WATCHDOG_EN_IN,
  input  wire logic        TEMP_RESTART_EN_IN,
  input  wire logic        TEMP_BACK_IN,
  input  wire logic        ILLEGAL_OPCODE_IN,
  input  wire logic        ILLEGAL_ADDRESS_IN,
  input  wire logic        SOFTWARE_TRAP_OPCODE_IN,
  input  wire logic        VECTOR_ACK_IN,
  output logic             IRQ_REQ_OUT,
  output logic             RESET_REQ_OUT,
  output logic             WAKE_OUT,
  output logic             VECTOR_VALID_OUT,
  output logic      [3:0]  VECTOR_NUM_OUT,
  output logic      [15:0] VECTOR_HI_ADDR_OUT,
  output logic      [15:0] VECTOR_LO_ADDR_OUT
);

  ivp_req_if    enc_bus ();
  ivp_lf_mode_t lf_mode;
  ivp_req_t     req;
  ivp_cause_t   cause_set;
  ivp_cause_t   cause_clr;
  ivp_cause_t   cause_r;
  ivp_cause_t   cause_nxt;
  logic         any_reset;
  logic         reset_pend_r;
  logic         reset_pend_nxt;
  logic         trap_pend_r;
  logic         trap_pend_nxt;
  logic         ack_reset;
  logic         ack_trap;
  logic         vec_valid_r;
  logic         vec_valid_nxt;
  ivp_vec_t     vec_num_r;
  ivp_vec_t     vec_num_nxt;
  ivp_addr_t    vec_hi_r;
  ivp_addr_t    vec_hi_nxt;
  ivp_addr_t    vec_lo_r;
  ivp_addr_t    vec_lo_nxt;
  logic         apb_setup;
  logic         apb_access;
  logic         addr_hit;
  logic [31:0]  prdata_r;
  logic [31:0]  prdata_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Request collection

  assign lf_mode = ivp_lf_mode_t'(LOWFREQ_MODE_IN);

  always_comb begin
    req = `IVP_REQ_RST;
    req[`IVP_VEC_KBD]   = KEYPAD_WAKE_FLAG_IN & KEYPAD_WAKE_IRQ_EN_IN;
    req[`IVP_VEC_TICK]  = PERIODIC_TICK_FLAG_IN & PERIODIC_TICK_IRQ_EN_IN;
    req[`IVP_VEC_LF]    =
        (lf_mode == IVP_LF_DATA && LOWFREQ_WAKE_ID_FLAG_IN && LOWFREQ_WAKE_ID_IRQ_EN_IN)
      | (lf_mode == IVP_LF_CARRIER && LOWFREQ_CARRIER_FLAG_IN
         && LOWFREQ_CARRIER_IRQ_EN_IN)
      | (lf_mode == IVP_LF_MANCH && LOWFREQ_DECODE_ERR_FLAG_IN
         && LOWFREQ_DECODE_ERR_IRQ_EN_IN)
      | (lf_mode == IVP_LF_MANCH && LOWFREQ_BYTE_RX_FLAG_IN
         && LOWFREQ_BYTE_RX_IRQ_EN_IN);
    req[`IVP_VEC_RADIO] = (RADIO_BUFFER_SENT_FLAG_IN | RADIO_TX_ERROR_FLAG_IN)
                          & RADIO_IRQ_EN_IN;
    req[`IVP_VEC_TOVF]  = TIMER_OVERFLOW_FLAG_IN & TIMER_OVERFLOW_IRQ_EN_IN;
    req[`IVP_VEC_CH1]   = TIMER_CHAN1_FLAG_IN & TIMER_CHAN1_IRQ_EN_IN;
    req[`IVP_VEC_CH0]   = TIMER_CHAN0_FLAG_IN & TIMER_CHAN0_IRQ_EN_IN;
    req[`IVP_VEC_WAKE]  = WAKEUP_INTERVAL_FLAG_IN & (|WAKEUP_INTERVAL_FIELD_IN);
    // Reset enable diverts low supply from interrupt to reset
    req[`IVP_VEC_LOWV]  = LOW_SUPPLY_FLAG_IN & LOW_SUPPLY_IRQ_EN_IN
                          & ~LOW_SUPPLY_RESET_EN_IN;
    req[`IVP_VEC_TRAP]  = trap_pend_r;
    req[`IVP_VEC_RESET] = reset_pend_r;
    req = req & ~`IVP_RSV_MASK;
  end

  assign enc_bus.req = req;

  ivp_prio_enc u_prio_enc (
    .bus (enc_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reset causes and software trap

  always_comb begin
    cause_set = `IVP_CAUSE_RST;
    cause_set[`IVP_CAUSE_POR]    = POWER_ON_RESET_IN;
    cause_set[`IVP_CAUSE_PERRST] = PERIODIC_RESET_FLAG_IN
                                   & (|PERIODIC_RESET_INTERVAL_IN);
    cause_set[`IVP_CAUSE_WDT]    = WATCHDOG_TIMEOUT_IN & WATCHDOG_EN_IN;
    cause_set[`IVP_CAUSE_LOWV]   = LOW_SUPPLY_FLAG_IN & LOW_SUPPLY_RESET_EN_IN;
    cause_set[`IVP_CAUSE_TEMP]   = TEMP_BACK_IN & TEMP_RESTART_EN_IN;
    cause_set[`IVP_CAUSE_ILLOP]  = ILLEGAL_OPCODE_IN;
    cause_set[`IVP_CAUSE_ILLADR] = ILLEGAL_ADDRESS_IN;
  end

  assign any_reset = |cause_set;
  assign ack_reset = VECTOR_ACK_IN & vec_valid_r & (vec_num_r == `IVP_VEC_RESET);
  assign ack_trap  = VECTOR_ACK_IN & vec_valid_r & (vec_num_r == `IVP_VEC_TRAP);
  assign cause_clr = (apb_access && PWRITE_IN && PADDR_IN == `IVP_OFS_CAUSE)
                     ? PWDATA_IN[6:0] : `IVP_CAUSE_RST;

  // Set wins over clear throughout
  always_comb begin
    cause_nxt      = (cause_r & ~cause_clr) | cause_set;
    reset_pend_nxt = (reset_pend_r & ~ack_reset) | any_reset;
    trap_pend_nxt  = (trap_pend_r & ~ack_trap) | SOFTWARE_TRAP_OPCODE_IN;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cause_r      <= `IVP_CAUSE_RST;
      reset_pend_r <= `IVP_RESET_PEND_RST;
      trap_pend_r  <= `IVP_TRAP_PEND_RST;
    end else begin
      cause_r      <= cause_nxt;
      reset_pend_r <= reset_pend_nxt;
      trap_pend_r  <= trap_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Vector presentation to the core

  always_comb begin
    vec_valid_nxt = enc_bus.valid;
    vec_num_nxt   = enc_bus.num;
    vec_hi_nxt    = enc_bus.addr;
    vec_lo_nxt    = enc_bus.addr + 16'h0001;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      vec_valid_r <= 1'b0;
      vec_num_r   <= `IVP_VEC_RESET;
      vec_hi_r    <= `IVP_VEC_TOP;
      vec_lo_r    <= `IVP_VEC_TOP + 16'h0001;
    end else begin
      vec_valid_r <= vec_valid_nxt;
      vec_num_r   <= vec_num_nxt;
      vec_hi_r    <= vec_hi_nxt;
      vec_lo_r    <= vec_lo_nxt;
    end
  end

  assign VECTOR_VALID_OUT   = vec_valid_r;
  assign VECTOR_NUM_OUT     = vec_num_r;
  assign VECTOR_HI_ADDR_OUT = vec_hi_r;
  assign VECTOR_LO_ADDR_OUT = vec_lo_r;
  assign RESET_REQ_OUT      = reset_pend_r;
  assign IRQ_REQ_OUT        = |req[15:2];
  assign WAKE_OUT           = |req;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign apb_setup  = PSEL_IN & ~PENABLE_IN;
  assign apb_access = PSEL_IN & PENABLE_IN;
  assign addr_hit   = (PADDR_IN == `IVP_OFS_PENDING) || (PADDR_IN == `IVP_OFS_CAUSE)
                      || (PADDR_IN == `IVP_OFS_VECTOR);

  // Read data captured in the setup cycle
  always_comb begin
    prdata_nxt = prdata_r;
    if (apb_setup) begin
      case (PADDR_IN)
        `IVP_OFS_PENDING: prdata_nxt = {16'h0000, req};
        `IVP_OFS_CAUSE:   prdata_nxt = {25'h0000000, cause_r};
        `IVP_OFS_VECTOR:  prdata_nxt = {vec_hi_r, 11'h000, vec_valid_r, vec_num_r};
        default:          prdata_nxt = `IVP_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      prdata_r <= `IVP_RDATA_RST;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign PRDATA_OUT  = prdata_r;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = apb_access & ~addr_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_kbd_vector: assert property (
    (KEYPAD_WAKE_FLAG_IN && KEYPAD_WAKE_IRQ_EN_IN && req[14:0] == 15'h0000
     && !any_reset && !SOFTWARE_TRAP_OPCODE_IN)
    |=> (VECTOR_VALID_OUT && VECTOR_NUM_OUT == 4'hF && VECTOR_HI_ADDR_OUT == 16'hDFE0))
    else $error("keypad request not presented as vector 15");

  a_radio_shared: assert property (
    ((RADIO_BUFFER_SENT_FLAG_IN || RADIO_TX_ERROR_FLAG_IN) && RADIO_IRQ_EN_IN
     && req[8:0] == 9'h000 && !any_reset && !SOFTWARE_TRAP_OPCODE_IN)
    |=> (VECTOR_VALID_OUT && VECTOR_NUM_OUT == 4'h9))
    else $error("radio vector not OR of gated flags");

  a_lf_manch_err: assert property (
    (lf_mode == IVP_LF_MANCH && LOWFREQ_DECODE_ERR_FLAG_IN && LOWFREQ_DECODE_ERR_IRQ_EN_IN)
    |-> req[`IVP_VEC_LF])
    else $error("decode error did not request vector 11");

  a_lf_mode_gate: assert property (
    (lf_mode == IVP_LF_OFF) |-> !req[`IVP_VEC_LF])
    else $error("receiver vector requested with no mode");

  a_lowv_to_reset: assert property (
    (LOW_SUPPLY_FLAG_IN && LOW_SUPPLY_RESET_EN_IN)
    |-> !req[`IVP_VEC_LOWV] ##1 RESET_REQ_OUT)
    else $error("low supply with reset enable did not reset");

  a_reserved_idle: assert property (
    (req & `IVP_RSV_MASK) == 16'h0000 && !(VECTOR_VALID_OUT && VECTOR_NUM_OUT == 4'h2))
    else $error("reserved vector requested");

  a_prio_order: assert property (
    (!$past(SRST_IN) && $past(enc_bus.valid)) |-> VECTOR_VALID_OUT
      && (($past(req) & ivp_above_mask(VECTOR_NUM_OUT)) == 16'h0000))
    else $error("lower-priority vector presented first");

  a_addr_pair: assert property (
    VECTOR_VALID_OUT |-> (VECTOR_LO_ADDR_OUT == VECTOR_HI_ADDR_OUT + 16'h0001)
      && (VECTOR_HI_ADDR_OUT == 16'hDFFE - {11'h000, VECTOR_NUM_OUT, 1'b0}))
    else $error("vector address pair wrong");

  a_reset_first: assert property (
    $fell(SRST_IN) |-> RESET_REQ_OUT ##1 (VECTOR_VALID_OUT && VECTOR_NUM_OUT == 4'h0))
    else $error("reset vector not fetched after reset");

  a_trap_vector: assert property (
    (SOFTWARE_TRAP_OPCODE_IN && !reset_pend_r && !any_reset)
    |=> trap_pend_r ##1 (VECTOR_NUM_OUT == 4'h1 || RESET_REQ_OUT))
    else $error("software trap not taken");

  a_cause_sticky: assert property (
    (ILLEGAL_OPCODE_IN || ILLEGAL_ADDRESS_IN) |=> cause_r[6:5] != 2'b00 && RESET_REQ_OUT)
    else $error("illegal access lost");

  a_wake_any: assert property (
    WAKE_OUT |=> VECTOR_VALID_OUT)
    else $error("request did not wake core");

  c_kbd_served: cover property (VECTOR_VALID_OUT && VECTOR_NUM_OUT == 4'hF);
  c_reset_acked: cover property (ack_reset ##1 !RESET_REQ_OUT);
  c_trap_acked: cover property (trap_pend_r ##[1:4] ack_trap);
  c_cause_clear: cover property (cause_r != 7'h00 ##1 cause_clr != 7'h00 ##1 cause_r == 7'h00);

endmodule : ivp_top

`default_nettype wire

// >>> include/ivp_map.svh
`ifndef IVP_MAP_SVH
`define IVP_MAP_SVH

// Register byte offsets
`define IVP_OFS_PENDING    12'h000
`define IVP_OFS_CAUSE      12'h004
`define IVP_OFS_VECTOR     12'h008

// Vector numbers
`define IVP_VEC_KBD        4'hF
`define IVP_VEC_TICK       4'hC
`define IVP_VEC_LF         4'hB
`define IVP_VEC_RADIO      4'h9
`define IVP_VEC_TOVF       4'h7
`define IVP_VEC_CH1        4'h6
`define IVP_VEC_CH0        4'h5
`define IVP_VEC_WAKE       4'h4
`define IVP_VEC_LOWV       4'h3
`define IVP_VEC_TRAP       4'h1
`define IVP_VEC_RESET      4'h0

// Jump table top entry and reserved slots
`define IVP_VEC_TOP        16'hDFFE
`define IVP_RSV_MASK       16'h6504

// Reset cause bit positions
`define IVP_CAUSE_POR      0
`define IVP_CAUSE_PERRST   1
`define IVP_CAUSE_WDT      2
`define IVP_CAUSE_LOWV     3
`define IVP_CAUSE_TEMP     4
`define IVP_CAUSE_ILLOP    5
`define IVP_CAUSE_ILLADR   6

// Reset values
`define IVP_CAUSE_RST      7'h00
`define IVP_RESET_PEND_RST 1'b1
`define IVP_TRAP_PEND_RST  1'b0
`define IVP_REQ_RST        16'h0000
`define IVP_RDATA_RST      32'h00000000

`endif

// >>> include/ivp_pkg.sv
`include "ivp_map.svh"

package ivp_pkg;

  typedef logic [15:0] ivp_req_t;
  typedef logic [3:0]  ivp_vec_t;
  typedef logic [15:0] ivp_addr_t;
  typedef logic [6:0]  ivp_cause_t;

  typedef enum logic [1:0] {
    IVP_LF_DATA,
    IVP_LF_CARRIER,
    IVP_LF_MANCH,
    IVP_LF_OFF
  } ivp_lf_mode_t;

  // High-byte location of a vector pair
  function automatic ivp_addr_t ivp_vec_addr(input ivp_vec_t v);
    ivp_vec_addr = `IVP_VEC_TOP - {11'h000, v, 1'b0};
  endfunction : ivp_vec_addr

  // Requests ranked above vector v
  function automatic ivp_req_t ivp_above_mask(input ivp_vec_t v);
    ivp_above_mask = ~({16'hFFFF} << v);
  endfunction : ivp_above_mask

endpackage : ivp_pkg

// >>> include/ivp_req_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ivp_req_if;
  import ivp_pkg::*;
  ivp_req_t  req;
  logic      valid;
  ivp_vec_t  num;
  ivp_addr_t addr;

  modport src (output req, input valid, input num, input addr);
  modport enc (input req, output valid, output num, output addr);
endinterface : ivp_req_if

`default_nettype wire

// >>> hw/ivp_prio_enc.sv
`timescale 1ns/10ps
`default_nettype none

module ivp_prio_enc
  import ivp_pkg::*;
(
  ivp_req_if.enc bus
);

  // Lowest pending number wins
  always_comb begin
    bus.valid = |bus.req;
    bus.num   = `IVP_VEC_KBD;
    for (int i = 15; i >= 0; i--) begin
      if (bus.req[i]) begin
        bus.num = 4'(i);
      end
    end
    bus.addr = ivp_vec_addr(bus.num);
  end

endmodule : ivp_prio_enc

`default_nettype wire

// >>> verif/ivp_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module ivp_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       valid_in,
  input  wire logic [3:0] num_in,
  input  wire logic       mask_in,
  input  wire logic [3:0] lag_in,
  output logic            ack_out
);
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic       ack_r;
  logic       ack_nxt;

  // Reset and trap vectors ignore the global mask
  always_comb begin
    wait_nxt = 4'h0;
    ack_nxt  = 1'b0;
    if (valid_in && !ack_r && (num_in < 4'h2 || !mask_in)) begin
      wait_nxt = (wait_r == lag_in) ? 4'h0 : wait_r + 4'h1;
      ack_nxt  = (wait_r == lag_in);
    end
  end

  always_ff @(posedge clk_in) begin
    wait_r <= srst_in ? 4'h0 : wait_nxt;
    ack_r  <= srst_in ? 1'b0 : ack_nxt;
  end

  assign ack_out = ack_r;
endmodule : ivp_cpu_model

`default_nettype wire

// >>> verif/tb_interrupt_vector_priority.sv
`timescale 1ns/10ps
`default_nettype none

module tb_interrupt_vector_priority;
  import ivp_pkg::*;

  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [12:0] f       = 13'h0000;
  logic [12:0] e       = 13'h0000;
  logic [6:0]  rc      = 7'h00;
  logic [6:0]  rce     = 7'h00;
  logic [1:0]  mode    = 2'h0;
  logic        trap    = 1'b0;
  logic        mask    = 1'b0;
  logic [3:0]  lag     = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, ack, irq, rst_req, wake, vvalid;
  ivp_vec_t    vnum;
  ivp_addr_t   vhi, vlo;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  logic [3:0]  vtab [13]  = '{4'hF, 4'hC, 4'hB, 4'hB, 4'hB, 4'hB, 4'h9, 4'h9, 4'h7,
                              4'h6, 4'h5, 4'h4, 4'h3};

  always #10 clk = ~clk;

  ivp_top u_dut (.CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .KEYPAD_WAKE_FLAG_IN(f[0]), .KEYPAD_WAKE_IRQ_EN_IN(e[0]),
    .PERIODIC_TICK_FLAG_IN(f[1]), .PERIODIC_TICK_IRQ_EN_IN(e[1]), .LOWFREQ_MODE_IN(mode),
    .LOWFREQ_WAKE_ID_FLAG_IN(f[2]), .LOWFREQ_WAKE_ID_IRQ_EN_IN(e[2]),
    .LOWFREQ_CARRIER_FLAG_IN(f[3]), .LOWFREQ_CARRIER_IRQ_EN_IN(e[3]),
    .LOWFREQ_DECODE_ERR_FLAG_IN(f[4]), .LOWFREQ_DECODE_ERR_IRQ_EN_IN(e[4]),
    .LOWFREQ_BYTE_RX_FLAG_IN(f[5]), .LOWFREQ_BYTE_RX_IRQ_EN_IN(e[5]),
    .RADIO_BUFFER_SENT_FLAG_IN(f[6]), .RADIO_TX_ERROR_FLAG_IN(f[7]), .RADIO_IRQ_EN_IN(e[6]),
    .TIMER_OVERFLOW_FLAG_IN(f[8]), .TIMER_OVERFLOW_IRQ_EN_IN(e[8]),
    .TIMER_CHAN1_FLAG_IN(f[9]), .TIMER_CHAN1_IRQ_EN_IN(e[9]),
    .TIMER_CHAN0_FLAG_IN(f[10]), .TIMER_CHAN0_IRQ_EN_IN(e[10]),
    .WAKEUP_INTERVAL_FLAG_IN(f[11]), .WAKEUP_INTERVAL_FIELD_IN({5'h00, e[11]}),
    .LOW_SUPPLY_FLAG_IN(f[12]), .LOW_SUPPLY_IRQ_EN_IN(e[12]), .LOW_SUPPLY_RESET_EN_IN(rce[3]),
    .POWER_ON_RESET_IN(rc[0]), .PERIODIC_RESET_FLAG_IN(rc[1]),
    .PERIODIC_RESET_INTERVAL_IN({5'h00, rce[1]}), .WATCHDOG_TIMEOUT_IN(rc[2]),
    .WATCHDOG_EN_IN(rce[2]), .TEMP_RESTART_EN_IN(rce[4]), .TEMP_BACK_IN(rc[4]),
    .ILLEGAL_OPCODE_IN(rc[5]), .ILLEGAL_ADDRESS_IN(rc[6]), .SOFTWARE_TRAP_OPCODE_IN(trap),
    .VECTOR_ACK_IN(ack), .IRQ_REQ_OUT(irq), .RESET_REQ_OUT(rst_req), .WAKE_OUT(wake),
    .VECTOR_VALID_OUT(vvalid), .VECTOR_NUM_OUT(vnum), .VECTOR_HI_ADDR_OUT(vhi),
    .VECTOR_LO_ADDR_OUT(vlo));

  ivp_cpu_model u_cpu (.clk_in(clk), .srst_in(srst), .valid_in(vvalid), .num_in(vnum),
    .mask_in(mask), .lag_in(lag), .ack_out(ack));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    n_mismatch++;
    $display("BAD %s expected done seen timeout", nm);
    print_verdict();
  endtask : hang

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang("apb ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for vector v, or for the reset request to drop when rst is set
  task automatic wv(input logic [3:0] v, input logic rst);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (rst ? rst_req === 1'b0 : vvalid === 1'b1 && vnum === v) break;
    end
    if (n == 40) hang("vector wait");
  endtask : wv

  task automatic chkv(input logic [3:0] v);
    logic [15:0] hi;
    hi = 16'hDFFE - {11'h000, v, 1'b0};
    wv(v, 1'b0);
    chk("vector number", 32'(v), 32'(vnum));
    chk("high byte addr", 32'(hi), 32'(vhi));
    chk("low byte addr", 32'(hi + 16'h0001), 32'(vlo));
    chk("wake", 32'h1, 32'(wake));
  endtask : chkv

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int j;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chkv(4'h0);
    wv(4'h0, 1'b1);
    $display("test reset vector done");
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      mode <= (i == 3) ? IVP_LF_CARRIER : (i == 4 || i == 5) ? IVP_LF_MANCH : IVP_LF_DATA;
      f[i] <= 1'b1;
      repeat (3) @(negedge clk);
      chk("unenabled irq", 32'h0, 32'(irq));
      chk("unenabled wake", 32'h0, 32'(wake));
      @(posedge clk);
      e[(i == 7) ? 6 : i] <= 1'b1;
      chkv(vtab[i]);
      chk("irq", 32'h1, 32'(irq));
      repeat (4) @(negedge clk);
      chk("held vector", 32'(vtab[i]), 32'(vnum));
      @(posedge clk);
      f[i] <= 1'b0;
      e <= 13'h0000;
    end
    $display("test single sources done");
    @(posedge clk);
    f <= 13'h1FFF;
    e <= 13'h1FFF;
    mode <= IVP_LF_MANCH;
    chkv(4'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk("pending", 32'h00009AF8, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("vector reg", 32'hDFF80013, rd);
    for (int k = 12; k > 0; k--) begin
      @(posedge clk);
      f[k] <= 1'b0;
      j = k - 1;
      while (j == 2 || j == 3) j--;
      chkv(vtab[j]);
    end
    @(posedge clk);
    f <= 13'h003C;
    mode <= IVP_LF_OFF;
    repeat (3) @(negedge clk);
    chk("receiver off", 32'h0, 32'(wake));
    @(posedge clk);
    f <= 13'h0038;
    mode <= IVP_LF_DATA;
    repeat (3) @(negedge clk);
    chk("wrong receiver mode", 32'h0, 32'(wake));
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test priority done");
    @(posedge clk);
    f <= 13'h1000;
    lag <= 4'h6;
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    chkv(4'h1);
    chkv(4'h3);
    $display("test trap done");
    @(posedge clk);
    f <= 13'h0000;
    e <= 13'h0000;
    mask <= 1'b1;
    rc[2] <= 1'b1;
    repeat (4) @(negedge clk);
    chk("disabled watchdog", 32'h0, 32'(rst_req));
    @(posedge clk);
    rc <= 7'h00;
    rce <= 7'h7F;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      if (i == 3) f[12] <= 1'b1;
      else rc[i] <= 1'b1;
      @(posedge clk);
      f <= 13'h0000;
      rc <= 7'h00;
      chkv(4'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("cause", 32'h1 << i, rd);
      apb(1'b1, 12'h004, 32'h0000007F);
      apb(1'b0, 12'h004, 32'h0);
      chk("cause cleared", 32'h0, rd);
      wv(4'h0, 1'b1);
    end
    $display("test reset causes done");
    print_verdict();
  end
endmodule : tb_interrupt_vector_priority

`default_nettype wire
